// [rtl/sm_exec_pkg.sv]
// Constants, encodings and state types for the shift/move/indirect execution unit.
// Assumes an 8-bit core with 7-bit file addresses and 16-bit data pointers.
package sm_exec_pkg;

  localparam int          DATA_W      = 8;
  localparam int          PTR_W       = 16;
  localparam int          FILE_AW     = 7;
  localparam int          OFS_W       = 6;
  localparam logic [6:0]  ALIAS0_ADDR = 7'h00;   // File slot that stands for pointer 0
  localparam logic [6:0]  ALIAS1_ADDR = 7'h01;   // File slot that stands for pointer 1
  localparam logic [8:0]  FILE_PAD    = 9'h000;  // Upper data address bits of a file access
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [15:0] PTR_RST     = 16'h0000;
  localparam logic [15:0] PTR_STEP    = 16'h0001;
  localparam logic        DEST_ACC    = 1'b0;

  typedef enum logic [1:0]
  {
    logical_right_shift_op = 2'h0,
    move_file_op           = 2'h1,
    indirect_load_op       = 2'h2
  } op_t;

  typedef enum logic [1:0]
  {
    PRE_INC  = 2'h0,
    PRE_DEC  = 2'h1,
    POST_INC = 2'h2,
    POST_DEC = 2'h3
  } ind_mode_t;

  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'h1,
    ST_FETCH = 4'h2,
    ST_EXEC  = 4'h4,
    ST_DONE  = 4'h8
  } state_t;

  typedef struct packed
  {
    logic [15:0] ptr;
  } ptr_state_t;

  typedef struct packed
  {
    state_t      state;
    op_t         op;
    logic        dest;
    ind_mode_t   mode;
    logic        rel;
    logic        ptrSel;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic [7:0]  acc;
    logic        carry;
    logic        zero;
    logic        done;
  } exec_state_t;

endpackage : sm_exec_pkg

// [rtl/indirect_pointer_reg.sv]
// One 16-bit indirect data pointer with load and +/-1 stepping.
// Assumes load and step come from logic on the same clock.
`timescale 1ns/1ps
module indirect_pointer_reg
  import sm_exec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] loadValue,
  input  wire logic        step,
  input  wire logic        stepDown,
  output logic      [15:0] value
);

  ptr_state_t s_q;
  ptr_state_t s_d;

  // Load wins over a step; stepping wraps modulo 2^16 by plain 16-bit arithmetic
  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.ptr = loadValue;
    end
    else if (step)
    begin
      s_d.ptr = stepDown ? s_q.ptr - PTR_STEP : s_q.ptr + PTR_STEP;
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_q.ptr <= PTR_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign value = s_q.ptr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_ptr_wrap_step: assert property (!load && step |=> value == ($past(stepDown) ?
      16'($past(value) - PTR_STEP) : 16'($past(value) + PTR_STEP)))
    else $error("pointer step did not wrap modulo 2^16");

endmodule : indirect_pointer_reg

// [rtl/shift_move_indirect_exec.sv]
// Execution unit for right shift, file move and indirect load of an 8-bit core.
// Assumes a data memory with one-cycle registered read and a same-clock decoder.
// Contract
// - Shift right: zero in, bit0 to carry
// - Shift updates carry and zero flags
// - Dest bit picks accumulator or file
// - Move copies file to chosen destination
// - Move updates zero flag from value
// - Indirect mode codes: pre/post inc/dec
// - Pre adjusts before access; post after
// - Relative offset access leaves pointer unchanged
// - Indirect load picks pointer, loads accumulator, zero
// - Alias file slots redirect through pointer
// - Pointers are 16-bit, wrap at ends
`timescale 1ns/1ps
module shift_move_indirect_exec
  import sm_exec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        opValid,
  output logic             opReady,
  input  wire logic [1:0]  opCode,
  input  wire logic [6:0]  fileAddr,
  input  wire logic        destSel,
  input  wire logic        ptrSel,
  input  wire logic [1:0]  indMode,
  input  wire logic        relMode,
  input  wire logic [5:0]  relOffset,
  input  wire logic        ptrLoad,
  input  wire logic        ptrLoadSel,
  input  wire logic [15:0] ptrLoadValue,
  output logic      [15:0] ptr0Value,
  output logic      [15:0] ptr1Value,
  output logic      [15:0] memAddr,
  output logic             memRead,
  output logic             memWrite,
  output logic      [7:0]  memWData,
  input  wire logic [7:0]  memRData,
  output logic      [7:0]  accValue,
  output logic             carryFlag,
  output logic             zeroFlag,
  output logic             opDone
);

  exec_state_t s_q;
  exec_state_t s_d;
  logic [15:0] ptrVal [2];
  logic [1:0]  ptrStep;
  logic        stepDown;
  logic        stepNow;
  logic        stepSel;
  logic [15:0] base;
  logic [7:0]  result;

  // Pointer currently chosen by the incoming indirect instruction
  assign base = ptrSel ? ptrVal[1] : ptrVal[0];

  // Pre modes step at accept, post modes once data has been read; relative never steps
  always_comb
  begin
    stepNow  = 1'b0;
    stepSel  = s_q.ptrSel;
    stepDown = s_q.mode[0];
    if (s_q.state == ST_IDLE)
    begin
      stepSel  = ptrSel;
      stepDown = indMode[0];
      stepNow  = opValid && op_t'(opCode) == indirect_load_op && !relMode
                 && !indMode[1];
    end
    else if (s_q.state == ST_EXEC)
    begin
      stepNow  = s_q.op == indirect_load_op && !s_q.rel && s_q.mode[1];
    end
    ptrStep = {stepNow && stepSel, stepNow && !stepSel};
  end

  // Two identical pointers
  for (genvar i = 0; i < 2; i++)
  begin : g_ptr
    indirect_pointer_reg indirect_pointer_reg_inst
    (
      .clock     (clock),
      .rst       (rst),
      .load      (ptrLoad && ptrLoadSel == 1'(i)),
      .loadValue (ptrLoadValue),
      .step      (ptrStep[i]),
      .stepDown  (stepDown),
      .value     (ptrVal[i])
    );
  end

  // Next-state logic for the whole instruction sequence
  always_comb
  begin
    s_d      = s_q;
    s_d.rd   = 1'b0;
    s_d.wr   = 1'b0;
    s_d.done = 1'b0;
    result   = memRData;
    case (s_q.state)
      ST_IDLE:
      begin
        if (opValid)
        begin
          s_d.op     = op_t'(opCode);
          s_d.dest   = destSel;
          s_d.mode   = ind_mode_t'(indMode);
          s_d.rel    = relMode;
          s_d.ptrSel = ptrSel;
          if (op_t'(opCode) == indirect_load_op)
          begin
            if (relMode)
            begin
              s_d.addr = base + {{10{relOffset[5]}}, relOffset};
            end
            else if (indMode == PRE_INC)
            begin
              s_d.addr = base + PTR_STEP;
            end
            else if (indMode == PRE_DEC)
            begin
              s_d.addr = base - PTR_STEP;
            end
            else
            begin
              s_d.addr = base;
            end
          end
          else if (fileAddr == ALIAS0_ADDR)
          begin
            s_d.addr = ptrVal[0];
          end
          else if (fileAddr == ALIAS1_ADDR)
          begin
            s_d.addr = ptrVal[1];
          end
          else
          begin
            s_d.addr = {FILE_PAD, fileAddr};
          end
          s_d.rd    = 1'b1;
          s_d.state = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        // Memory samples the read here; data is valid in the next cycle
        s_d.state = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (s_q.op == logical_right_shift_op)
        begin
          result    = {1'b0, memRData[7:1]};
          s_d.carry = memRData[0];
        end
        s_d.zero = result == 8'h00;
        if (s_q.op == indirect_load_op || s_q.dest == DEST_ACC)
        begin
          s_d.acc = result;
        end
        else
        begin
          s_d.wr    = 1'b1;
          s_d.wdata = result;
        end
        s_d.done  = 1'b1;
        s_d.state = ST_DONE;
      end
      ST_DONE:
      begin
        s_d.state = ST_IDLE;
      end
      default:
      begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  // State register; flags and accumulator clear on reset and otherwise change only in the execute step
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_q.state  <= ST_IDLE;
      s_q.op     <= logical_right_shift_op;
      s_q.dest   <= DEST_ACC;
      s_q.mode   <= PRE_INC;
      s_q.rel    <= 1'b0;
      s_q.ptrSel <= 1'b0;
      s_q.addr   <= PTR_RST;
      s_q.rd     <= 1'b0;
      s_q.wr     <= 1'b0;
      s_q.wdata  <= ACC_RST;
      s_q.acc    <= ACC_RST;
      s_q.carry  <= 1'b0;
      s_q.zero   <= 1'b0;
      s_q.done   <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs: ready is combinational, pointer values come from the pointer registers, everything else from the state register
  assign opReady   = s_q.state == ST_IDLE;
  assign memAddr   = s_q.addr;
  assign memRead   = s_q.rd;
  assign memWrite  = s_q.wr;
  assign memWData  = s_q.wdata;
  assign accValue  = s_q.acc;
  assign carryFlag = s_q.carry;
  assign zeroFlag  = s_q.zero;
  assign opDone    = s_q.done;
  assign ptr0Value = ptrVal[0];
  assign ptr1Value = ptrVal[1];

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_shift_carry_out: assert property (opDone && s_q.op == logical_right_shift_op |->
      carryFlag == $past(memRData[0]))
    else $error("shift carry is not source bit 0");
  a_shift_result_val: assert property (opDone && s_q.op == logical_right_shift_op |->
      (memWrite ? memWData : accValue) == {1'b0, $past(memRData[7:1])})
    else $error("shift result malformed");
  a_zero_flag_val: assert property (opDone |->
      zeroFlag == ((memWrite ? memWData : accValue) == 8'h00))
    else $error("zero flag disagrees with result");
  // A write strobe here would overwrite the file that the instruction only read
  a_acc_dest_nowr: assert property (opDone && (s_q.dest == DEST_ACC ||
      s_q.op == indirect_load_op) |-> !memWrite)
    else $error("file written for accumulator destination");
  a_file_dest_wr: assert property (opDone && s_q.dest != DEST_ACC &&
      s_q.op != indirect_load_op |-> memWrite && accValue == $past(accValue))
    else $error("file destination not written back");
  a_move_copy_val: assert property (opDone && s_q.op != logical_right_shift_op |->
      (memWrite ? memWData : accValue) == $past(memRData))
    else $error("move or load value differs from memory");
  a_op_latency_3: assert property (opValid && opReady |=> !opReady [*3] ##1 opReady)
    else $error("instruction did not take three cycles");
  a_rel_ptr_keep: assert property (opValid && opReady && op_t'(opCode) == indirect_load_op
      && relMode && !ptrLoad |=> memAddr == 16'($past(base) + {{10{$past(relOffset[5])}},
      $past(relOffset)}) ##0 (ptrVal[s_q.ptrSel] == $past(base)) [*3])
    else $error("relative access address or pointer wrong");
  a_pre_inc_addr: assert property (opValid && opReady && op_t'(opCode) ==
      indirect_load_op && !relMode && indMode == PRE_INC && !ptrLoad |=>
      memAddr == 16'($past(base) + PTR_STEP) && ptrVal[s_q.ptrSel] == memAddr)
    else $error("pre-increment address or pointer wrong");
  a_post_dec_addr: assert property (opValid && opReady && op_t'(opCode) ==
      indirect_load_op && !relMode && indMode == POST_DEC && !ptrLoad |=>
      memAddr == $past(base) ##1 ptrStep != 2'b00 && stepDown)
    else $error("post-decrement address or step wrong");
  a_alias_redirect: assert property (opValid && opReady && op_t'(opCode) !=
      indirect_load_op && fileAddr == ALIAS1_ADDR |=> memAddr == $past(ptrVal[1]))
    else $error("alias slot not redirected through pointer");

  c_shift_to_file: cover property (opDone && s_q.op == logical_right_shift_op && memWrite);
  c_move_zero_test: cover property (opDone && s_q.op == move_file_op && zeroFlag);
  c_post_inc_load: cover property (opDone && s_q.op == indirect_load_op && s_q.mode == POST_INC);
  c_rel_negative: cover property (opValid && opReady && relMode && relOffset[5]);

endmodule : shift_move_indirect_exec

// [rtl/_unused_placeholder_removed.sv]
// Intentionally empty; no design content.

// [sim/test_shift_move_indirect_exec.sv]
// Self-checking bench for the shift, file move and indirect load unit.
// Assumes the bench stands in for data memory and answers a read one cycle after memRead.
`timescale 1ns/1ps
module test_shift_move_indirect_exec;
  import sm_exec_pkg::*;

  logic        clock, rst, opValid, destSel, ptrSel, relMode, ptrLoad, ptrLoadSel;
  logic [1:0]  opCode, indMode;
  logic [6:0]  fileAddr;
  logic [5:0]  relOffset;
  logic [15:0] ptrLoadValue, ptr0Value, ptr1Value, memAddr, rdAddr, wrAddr;
  logic [7:0]  memRData, memWData, accValue, wrData;
  logic        opReady, memRead, memWrite, carryFlag, zeroFlag, opDone, wrSeen;
  logic [7:0]  mem [logic [15:0]];
  int          miscompares, compares;

  shift_move_indirect_exec shift_move_indirect_exec_inst (
    .clock(clock), .rst(rst), .opValid(opValid), .opReady(opReady), .opCode(opCode),
    .fileAddr(fileAddr), .destSel(destSel), .ptrSel(ptrSel), .indMode(indMode),
    .relMode(relMode), .relOffset(relOffset), .ptrLoad(ptrLoad), .ptrLoadSel(ptrLoadSel),
    .ptrLoadValue(ptrLoadValue), .ptr0Value(ptr0Value), .ptr1Value(ptr1Value),
    .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .memWData(memWData),
    .memRData(memRData), .accValue(accValue), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
    .opDone(opDone));

  always #5 clock = ~clock;

  // Unwritten locations hold a pattern tied to the address, so a wrong address shows
  function automatic logic [7:0] rdByte(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h3C);
  endfunction : rdByte

  // Memory stand-in; outside a read the bus scrambles so stale data cannot pass
  always @(posedge clock)
  begin
    if (memWrite)
      mem[memAddr] = memWData;
    memRData <= #1 memRead ? rdByte(memAddr) : ~memRData;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Loads a pointer; the new value must show one cycle later
  task automatic loadPtr(input logic s, input logic [15:0] v);
    ptrLoad = 1'h1;
    ptrLoadSel = s;
    ptrLoadValue = v;
    @(posedge clock);
    #1;
    ptrLoad = 1'h0;
    check(s ? ptr1Value : ptr0Value, v, "pointer load");
  endtask : loadPtr

  // Issues one instruction and follows it through its four-cycle slot
  task automatic runOp(input op_t op, input logic [6:0] f, input logic d, input logic ps,
                       input logic [1:0] md, input logic rl, input logic [5:0] ofs);
    int n;
    n = 0;
    while (opReady !== 1'h1)
    begin
      @(posedge clock);
      #1;
      n++;
      if (n > 20)
      begin
        miscompares++;
        final_report();
      end
    end
    opCode = op;
    fileAddr = f;
    destSel = d;
    ptrSel = ps;
    indMode = md;
    relMode = rl;
    relOffset = ofs;
    opValid = 1'h1;
    @(posedge clock);
    #1;
    opValid = 1'h0;
    check(memRead, 1'h1, "read strobe");
    rdAddr = memAddr;
    repeat (2) @(posedge clock);
    #1;
    check(opDone, 1'h1, "done timing");
    wrSeen = memWrite;
    wrAddr = memAddr;
    wrData = memWData;
  endtask : runOp

  task automatic testShift;
    mem[16'h0010] = 8'h81;
    mem[16'h0011] = 8'h01;
    mem[16'h0012] = 8'hFE;
    runOp(logical_right_shift_op, 7'h10, DEST_ACC, 1'h0, 2'h0, 1'h0, 6'h00);
    check(rdAddr, 16'h0010, "shift address");
    check(accValue, 8'h40, "shift result");
    check(carryFlag, 1'h1, "carry from bit 0");
    check(zeroFlag, 1'h0, "zero clear");
    check(wrSeen, 1'h0, "no file write");
    runOp(logical_right_shift_op, 7'h11, 1'h1, 1'h0, 2'h0, 1'h0, 6'h00);
    check(wrSeen, 1'h1, "write back");
    check(wrAddr, 16'h0011, "write address");
    check(wrData, 8'h00, "written result");
    check(zeroFlag, 1'h1, "zero set");
    check(accValue, 8'h40, "acc kept");
    runOp(logical_right_shift_op, 7'h12, DEST_ACC, 1'h0, 2'h0, 1'h0, 6'h00);
    check(accValue, 8'h7F, "top bit cleared");
    check(carryFlag, 1'h0, "carry clear");
    check(mem[16'h0012], 8'hFE, "file untouched");
    $display("shift test done");
  endtask : testShift

  task automatic testMove;
    mem[16'h007F] = 8'h00;
    mem[16'h0020] = 8'hA5;
    runOp(move_file_op, 7'h7F, 1'h1, 1'h0, 2'h0, 1'h0, 6'h00);
    check(wrAddr, 16'h007F, "move top address");
    check(wrData, 8'h00, "move data");
    check(zeroFlag, 1'h1, "zero test");
    check(accValue, 8'h7F, "acc kept");
    runOp(move_file_op, 7'h20, DEST_ACC, 1'h0, 2'h0, 1'h0, 6'h00);
    check(accValue, 8'hA5, "move to acc");
    check(zeroFlag, 1'h0, "zero clear");
    check(wrSeen, 1'h0, "no file write");
    $display("move test done");
  endtask : testMove

  // Every update mode in turn; both pre modes and post-decrement start at an end of the range, post-increment from 1234
  task automatic testIndirect;
    logic [15:0] st;
    logic [15:0] nx;
    logic [15:0] ea;
    logic [15:0] starts [4] = '{16'hFFFF, 16'h0000, 16'h1234, 16'h0000};
    mem[16'h1234] = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      st = starts[i];
      nx = i[0] ? st - 16'h0001 : st + 16'h0001;
      ea = i[1] ? st : nx;
      loadPtr(i[0], st);
      runOp(indirect_load_op, 7'h00, 1'h1, i[0], i[1:0], 1'h0, 6'h00);
      check(rdAddr, ea, "effective address");
      check(i[0] ? ptr1Value : ptr0Value, nx, "pointer after");
      check(accValue, rdByte(ea), "loaded byte");
      check(zeroFlag, rdByte(ea) == 8'h00, "zero from load");
      check(wrSeen, 1'h0, "load writes acc only");
    end
    $display("indirect test done");
  endtask : testIndirect

  task automatic testRelative;
    logic [5:0]  ofs [2] = '{6'h20, 6'h1F};
    logic [15:0] ea;
    loadPtr(1'h1, 16'h0010);
    for (int i = 0; i < 2; i++)
    begin
      ea = 16'h0010 + {{10{ofs[i][5]}}, ofs[i]};
      runOp(indirect_load_op, 7'h00, 1'h0, 1'h1, 2'h0, 1'h1, ofs[i]);
      check(rdAddr, ea, "offset address");
      check(ptr1Value, 16'h0010, "pointer unchanged");
      check(accValue, rdByte(ea), "offset byte");
    end
    $display("relative test done");
  endtask : testRelative

  // Alias slots have no storage; both read and write go through the pointer
  task automatic testAlias;
    loadPtr(1'h0, 16'h0345);
    @(posedge clock);
    #1;
    loadPtr(1'h1, 16'h0456);
    mem[16'h0345] = 8'h80;
    mem[16'h0456] = 8'h03;
    runOp(move_file_op, ALIAS0_ADDR, 1'h1, 1'h0, 2'h0, 1'h0, 6'h00);
    check(rdAddr, 16'h0345, "alias 0 read");
    check(wrAddr, 16'h0345, "alias 0 write");
    runOp(logical_right_shift_op, ALIAS1_ADDR, 1'h1, 1'h0, 2'h0, 1'h0, 6'h00);
    check(rdAddr, 16'h0456, "alias 1 read");
    // The write strobe stands in this cycle; the store lands at its closing edge
    @(posedge clock);
    #1;
    check(mem[16'h0456], 8'h01, "alias 1 stored");
    check(carryFlag, 1'h1, "alias carry");
    $display("alias test done");
  endtask : testAlias

  initial
  begin
    clock = 1'h0;
    rst = 1'h1;
    opValid = 1'h0;
    destSel = 1'h0;
    ptrSel = 1'h0;
    relMode = 1'h0;
    ptrLoad = 1'h0;
    ptrLoadSel = 1'h0;
    opCode = 2'h0;
    indMode = 2'h0;
    fileAddr = 7'h00;
    relOffset = 6'h00;
    ptrLoadValue = 16'h0000;
    miscompares = 0;
    compares = 0;
    repeat (16) @(posedge clock);
    #1;
    rst = 1'h0;
    testShift();
    testMove();
    testIndirect();
    testRelative();
    testAlias();
    final_report();
  end

endmodule : test_shift_move_indirect_exec
